// ### dcm_map.svh
// Operation
// R1: Monitor flag clears only by a register read seeing it set, then a zero write.
// R2: Service routine first reads the control register to confirm the monitor flag.
// R3: Service routine clears monitor-on after clearing the flag.
// R4: Monitor-on stays set even if a stable indication later drops.
// R5: Software sets the external-slow option to match the external clock.
// R6: Software uses the monitor only with both generators enabled and running.
// R7: On inactivity the dead source is deselected; both output clocks use the live one.
// R8: After an automatic switch the source select bit shows the surviving source.
// R9: Output period set by 8-bit stage control and 4-bit divider exponent.
// R10: Divider is two to the exponent; codes above 9 act as 9 (divide by 512).
// R11: Divider exponent steps only on stage control carry or borrow.
// R12: Upper three stage bits pick ring length 17 to 31 in steps of two.
// R13: Lower five stage bits k lengthen the ring by two for k of 32 cycles.
// R14: At upper code 7 the long point is 17 stages halved, 34 effective.
// R15: Internal frequency equals multiply factor times 307.2 kHz base.
// R16: Software disables the monitor before changing the multiply factor.
// R17: Software re-enables the monitor only after internal stable is set again.
// R18: Frequency change: check flag, monitor off, switch, write factor, restore; retune does no source switch.
// R19: Source select set picks the external clock, clear picks internal.
// R20: Software sets monitor-on only while both stable indications are set; retune tests only internal stable, and the hardware gates the set on both.
// R21: Interrupt request is high while monitor flag and its enable are both set.
`ifndef DCM_MAP_SVH
`define DCM_MAP_SVH
`define DCM_ADDR_CTRL     4'h0
`define DCM_ADDR_MULT     4'h1
`define DCM_ADDR_LOOP     4'h2
`define DCM_BIT_SEL       0
`define DCM_BIT_FLAG      1
`define DCM_BIT_MON       2
`define DCM_BIT_IE        3
`define DCM_BIT_INT_STB   4
`define DCM_BIT_EXT_STB   5
`define DCM_BIT_SLOW      6
`define DCM_MULT_RESET    7'h15
`define DCM_STAGE_RESET   8'h00
`define DCM_DIV_MAX       4'h9
`define DCM_RING_BASE     6'h11
`define DCM_FINE_PERIOD   6'h20
`define DCM_BASE_HZ       307200
`endif

// ### dcm_pkg.sv
package dcm_pkg;
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } dcm_bus_t;

    typedef struct packed {
        logic [3:0] divider_exponent;
        logic [7:0] stage_control;
    } dcm_dco_t;

    typedef enum logic [1:0] {
        DCM_LF_HOLD,
        DCM_LF_UP,
        DCM_LF_DOWN,
        DCM_LF_RSVD
    } dcm_lf_cmd_t;
endpackage : dcm_pkg

// ### dcm_top.sv
`timescale 1ns/1ps
`include "dcm_map.svh"

module dcm_top (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire dcm_pkg::dcm_bus_t bus_i,
    output logic [7:0]             rdata_o,
    input  wire logic              internal_stable_i,
    input  wire logic              external_stable_i,
    input  wire logic              internal_off_i,
    input  wire logic              external_off_i,
    input  wire dcm_pkg::dcm_lf_cmd_t loop_filter_i,
    output dcm_pkg::dcm_dco_t      dco_o,
    output logic [9:0]             divide_ratio_o,
    output logic [5:0]             ring_stages_o,
    output logic                   ring_halve_o,
    output logic [6:0]             multiply_factor_o,
    output logic                   external_slow_option_o,
    output logic                   osc_sel_external_o,
    output logic                   timebase_sel_external_o,
    output logic                   irq_o
);
    import dcm_pkg::*;

    logic       clock_select;
    logic       monitor_fault_flag;
    logic       monitor_on;
    logic       monitor_interrupt_enable;
    logic       external_slow_option;
    logic       flag_armed;
    logic [6:0] multiply_factor;
    logic [3:0] divider_exponent;
    logic [7:0] stage_control;
    logic [4:0] fine_phase;
    logic       fault_event;
    logic       wr_ctrl;
    logic [7:0] ctrl_view;
    logic       rd_ctrl;
    logic       wr_mult;
    logic       carry_out;
    logic       borrow_out;
    logic       long_point;
    logic       top_code;

    // ==========================================================
    // Helpers
    // ==========================================================
    function automatic logic [3:0] clamp_div(input logic [3:0] e);
        clamp_div = (e > `DCM_DIV_MAX) ? `DCM_DIV_MAX : e;
    endfunction : clamp_div

    function automatic logic [5:0] ring_base(input logic [2:0] code);
        ring_base = `DCM_RING_BASE + {2'b00, code, 1'b0};
    endfunction : ring_base

    function automatic logic reg_hit(input dcm_bus_t b, input logic [3:0] a);
        reg_hit = (b.addr == a);
    endfunction : reg_hit

    assign wr_ctrl     = bus_i.wr && reg_hit(bus_i, `DCM_ADDR_CTRL);
    assign rd_ctrl     = bus_i.rd && reg_hit(bus_i, `DCM_ADDR_CTRL);
    assign wr_mult     = bus_i.wr && reg_hit(bus_i, `DCM_ADDR_MULT);
    assign fault_event = monitor_on && (internal_off_i || external_off_i);

    always_comb begin
        ctrl_view                    = 8'h00;
        ctrl_view[`DCM_BIT_SEL]      = clock_select;
        ctrl_view[`DCM_BIT_FLAG]     = monitor_fault_flag;
        ctrl_view[`DCM_BIT_MON]      = monitor_on;
        ctrl_view[`DCM_BIT_IE]       = monitor_interrupt_enable;
        ctrl_view[`DCM_BIT_INT_STB]  = internal_stable_i;
        ctrl_view[`DCM_BIT_EXT_STB]  = external_stable_i;
        ctrl_view[`DCM_BIT_SLOW]     = external_slow_option;
    end

    // ==========================================================
    // Register read port
    // ==========================================================
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_o <= 8'h00;
        end else if (bus_i.rd) begin
            case (bus_i.addr)
                `DCM_ADDR_CTRL: rdata_o <= ctrl_view;
                `DCM_ADDR_MULT: rdata_o <= {1'b0, multiply_factor};
                `DCM_ADDR_LOOP: rdata_o <= stage_control;
                default:        rdata_o <= 8'h00;
            endcase
        end else begin
            rdata_o <= 8'h00;
        end
    end

    // ==========================================================
    // Monitor flag with read-then-write-zero clearing
    // ==========================================================
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flag_armed <= 1'b0;
        end else if (!monitor_fault_flag) begin
            flag_armed <= 1'b0;
        end else if (rd_ctrl) begin
            flag_armed <= 1'b1; // [R1] [R2]
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            monitor_fault_flag <= 1'b0;
        end else if (fault_event) begin
            monitor_fault_flag <= 1'b1; // Set wins over clear.
        end else if (wr_ctrl && flag_armed && !bus_i.wdata[`DCM_BIT_FLAG]) begin
            monitor_fault_flag <= 1'b0; // [R1]
        end
    end

    // ==========================================================
    // Control bits
    // ==========================================================
    // Setting the monitor needs both sources stable, but only reset or a software write
    // clears it, so a later loss of stability leaves it on.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            monitor_on <= 1'b0;
        end else if (wr_ctrl) begin // [R4]
            if (!bus_i.wdata[`DCM_BIT_MON]) begin
                monitor_on <= 1'b0; // [R3]
            end else if (internal_stable_i && external_stable_i) begin
                monitor_on <= 1'b1; // [R20]
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            monitor_interrupt_enable <= 1'b0;
        end else if (wr_ctrl) begin
            monitor_interrupt_enable <= bus_i.wdata[`DCM_BIT_IE]; // [R21]
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            external_slow_option <= 1'b0;
        end else if (wr_ctrl) begin
            external_slow_option <= bus_i.wdata[`DCM_BIT_SLOW]; // [R5]
        end
    end

    // ==========================================================
    // Source select
    // ==========================================================
    // A fault forces the live source at once; internal loss is tested first,
    // so a double loss leaves the external side selected.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clock_select <= 1'b0;
        end else if (fault_event && internal_off_i) begin
            clock_select <= 1'b1; // [R7] [R8]
        end else if (fault_event && external_off_i) begin
            clock_select <= 1'b0; // [R7] [R8]
        end else if (wr_ctrl) begin
            if (bus_i.wdata[`DCM_BIT_SEL] ? external_stable_i : internal_stable_i) begin
                clock_select <= bus_i.wdata[`DCM_BIT_SEL]; // [R19]
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            multiply_factor <= `DCM_MULT_RESET;
        end else if (wr_mult) begin
            multiply_factor <= bus_i.wdata[6:0]; // [R15]
        end
    end

    // ==========================================================
    // Loop filter accumulation into stage and divider
    // ==========================================================
    // The exponent never takes a step of its own: it moves only on a carry out
    // of or a borrow into the stage word, and both ends saturate.
    assign carry_out  = (loop_filter_i == DCM_LF_UP) && (stage_control == 8'hFF)
                        && (divider_exponent < `DCM_DIV_MAX);
    assign borrow_out = (loop_filter_i == DCM_LF_DOWN) && (stage_control == 8'h00)
                        && (divider_exponent != 4'h0);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stage_control <= `DCM_STAGE_RESET;
        end else begin
            case (loop_filter_i)
                DCM_LF_UP: begin
                    if (stage_control != 8'hFF) begin
                        stage_control <= stage_control + 8'h01; // [R9]
                    end else if (carry_out) begin
                        stage_control <= 8'h00;
                    end
                end
                DCM_LF_DOWN: begin
                    if (stage_control != 8'h00) begin
                        stage_control <= stage_control - 8'h01; // [R9]
                    end else if (borrow_out) begin
                        stage_control <= 8'hFF;
                    end
                end
                default: begin
                    stage_control <= stage_control;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            divider_exponent <= 4'h0;
        end else if (carry_out) begin
            divider_exponent <= divider_exponent + 4'h1; // [R11]
        end else if (borrow_out) begin
            divider_exponent <= divider_exponent - 4'h1; // [R11]
        end
    end

    // ==========================================================
    // Divider and ring length with fine adjust
    // ==========================================================
    // The fine phase runs free, so a fine value k picks the long point for
    // exactly k of every 32 cycles whatever phase it was loaded at.
    assign long_point = (fine_phase < stage_control[4:0]);
    assign top_code   = (stage_control[7:5] == 3'h7);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fine_phase <= 5'h00;
        end else begin
            fine_phase <= fine_phase + 5'h01;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            divide_ratio_o <= 10'h001;
        end else begin
            divide_ratio_o <= 10'h001 << clamp_div(divider_exponent); // [R10]
        end
    end

    // At the top code the long point would need 33 stages, which the ring lacks,
    // so it runs 17 stages and the halving stage doubles that.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ring_stages_o <= `DCM_RING_BASE;
        end else if (long_point && top_code) begin
            ring_stages_o <= `DCM_RING_BASE; // [R14]
        end else if (long_point) begin
            ring_stages_o <= ring_base(stage_control[7:5]) + 6'h02; // [R13]
        end else begin
            ring_stages_o <= ring_base(stage_control[7:5]); // [R12]
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ring_halve_o <= 1'b0;
        end else begin
            ring_halve_o <= long_point && top_code; // [R14]
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dco_o <= '0;
        end else begin
            dco_o <= '{clamp_div(divider_exponent), stage_control}; // [R9]
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            multiply_factor_o <= `DCM_MULT_RESET;
        end else begin
            multiply_factor_o <= multiply_factor; // [R15]
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            external_slow_option_o <= 1'b0;
        end else begin
            external_slow_option_o <= external_slow_option; // [R5]
        end
    end

    // Both clock switches follow the one select, so a fault moves them together.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            osc_sel_external_o      <= 1'b0;
            timebase_sel_external_o <= 1'b0;
        end else begin
            osc_sel_external_o      <= clock_select; // [R7] [R19]
            timebase_sel_external_o <= clock_select; // [R7]
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= monitor_fault_flag && monitor_interrupt_enable; // [R21]
        end
    end
endmodule : dcm_top

// ### dcm_top_asserts.sv
`timescale 1ns/1ps
// ==========
// Port checks for the clock control block.
module dcm_top_asserts (
    input wire logic              clk_i,
    input wire logic              rst_i,
    input wire dcm_pkg::dcm_bus_t bus_i,
    input wire dcm_pkg::dcm_dco_t dco_o,
    input wire logic [9:0]        divide_ratio_o,
    input wire logic [5:0]        ring_stages_o,
    input wire logic              ring_halve_o,
    input wire logic [6:0]        multiply_factor_o,
    input wire logic              osc_sel_external_o,
    input wire logic              timebase_sel_external_o,
    input wire logic              irq_o
);
    import dcm_pkg::*;
    logic [7:0] stg;
    logic [3:0] ex;
    logic [5:0] base;
    assign stg  = dco_o.stage_control;
    assign ex   = dco_o.divider_exponent;
    assign base = 6'h11 + {2'h0, stg[7:5], 1'h0};
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    exp_max_a: assert property (ex <= 4'h9)
        else $error("exponent above nine");
    div_ratio_a: assert property ($stable(ex) |-> divide_ratio_o == (10'h001 << ex))
        else $error("ratio not two to the exponent");
    exp_carry_a: assert property ($changed(ex) |->
        ($past(stg) == 8'hFF && stg == 8'h00) || ($past(stg) == 8'h00 && stg == 8'hFF))
        else $error("exponent moved without carry");
    stage_step_a: assert property ($changed(stg) |->
        stg == 8'($past(stg) + 8'h01) || stg == 8'($past(stg) - 8'h01))
        else $error("stage moved by more than one");
    ring_len_a: assert property ($stable(stg) && stg[7:5] != 3'h7 |->
        ring_stages_o == base || (stg[4:0] != 5'h00 && ring_stages_o == base + 6'h02))
        else $error("ring length wrong");
    ring_halve_a: assert property (ring_halve_o && $stable(stg) |-> stg[7:5] == 3'h7)
        else $error("halving outside top code");
    sel_pair_a: assert property (osc_sel_external_o == timebase_sel_external_o)
        else $error("clock selects differ");
    irq_fall_a: assert property ($fell(irq_o) |->
        $past(bus_i.wr && bus_i.addr == 4'h0, 2))
        else $error("request dropped without a write");
    factor_load_a: assert property ($changed(multiply_factor_o) |->
        $past(bus_i.wr && bus_i.addr == 4'h1, 2))
        else $error("factor moved without a write");
endmodule : dcm_top_asserts
bind dcm_top dcm_top_asserts chk (.clk_i, .rst_i, .bus_i, .dco_o, .divide_ratio_o,
    .ring_stages_o, .ring_halve_o, .multiply_factor_o, .osc_sel_external_o,
    .timebase_sel_external_o, .irq_o);

// ### dcm_cpu.sv
`timescale 1ns/1ps
// ==========
// Software side: register cycles and service routines.
module dcm_cpu (
    input  wire logic        clk_i,
    input  wire logic [7:0]  rdata_i,
    output dcm_pkg::dcm_bus_t bus_o
);
    import dcm_pkg::*;
    initial bus_o = '0;
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        bus_o <= '{a, d, 1'b1, 1'b0};
        @(posedge clk_i);
        bus_o <= '0;
        @(posedge clk_i);
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        bus_o <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk_i);
        bus_o <= '0;
        @(posedge clk_i);
        d = rdata_i;
    endtask : rd
    task automatic service(output logic [7:0] s);
        rd(4'h0, s);
        wr(4'h0, s & 8'hFD);
        wr(4'h0, s & 8'hF9);
    endtask : service
    task automatic retune(input logic [6:0] n);
        logic [7:0] s;
        rd(4'h0, s);
        wr(4'h0, s & 8'hFB);
        wr(4'h1, {1'b0, n});
        rd(4'h0, s);
        if (s[4]) begin
            wr(4'h0, s | 8'h04);
        end
    endtask : retune
endmodule : dcm_cpu

// ### tb_top.sv
`timescale 1ns/1ps
// ==========
// Self-checking bench for the clock control block.
module tb_top;
    import dcm_pkg::*;
    typedef struct packed {logic [3:0] a; logic [7:0] d, e;} dcm_row_t;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        internal_stable_i = 1'b1;
    logic        external_stable_i = 1'b1;
    logic        internal_off_i = 1'b0;
    logic        external_off_i = 1'b0;
    dcm_lf_cmd_t loop_filter_i = DCM_LF_HOLD;
    dcm_bus_t    bus_i;
    dcm_dco_t    dco_o;
    logic [7:0]  rdata_o, s;
    logic [9:0]  divide_ratio_o;
    logic [5:0]  ring_stages_o;
    logic [6:0]  multiply_factor_o;
    logic        ring_halve_o, external_slow_option_o, irq_o;
    logic        osc_sel_external_o, timebase_sel_external_o;
    int          err_total = 0;
    int          checks = 0;
    int          k;
    dcm_row_t    rows [7] = '{'{4'h1, 8'h2A, 8'h2A}, '{4'h1, 8'hFF, 8'h7F},
        '{4'h0, 8'h42, 8'h70}, '{4'h0, 8'h09, 8'h39}, '{4'h0, 8'h00, 8'h30},
        '{4'h3, 8'h55, 8'h00}, '{4'h2, 8'h77, 8'h00}};
    always #4 clk_i = ~clk_i;
    dcm_cpu cpu (.clk_i, .rdata_i(rdata_o), .bus_o(bus_i));
    dcm_top DUT (.clk_i, .rst_i, .bus_i, .rdata_o, .internal_stable_i, .external_stable_i,
        .internal_off_i, .external_off_i, .loop_filter_i, .dco_o, .divide_ratio_o,
        .ring_stages_o, .ring_halve_o, .multiply_factor_o, .external_slow_option_o,
        .osc_sel_external_o, .timebase_sel_external_o, .irq_o);
    task automatic chk(input string n, input logic [9:0] e, input logic [9:0] g);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic steer(input dcm_lf_cmd_t c, input int n);
        loop_filter_i <= c;
        repeat (n) @(posedge clk_i);
        loop_filter_i <= DCM_LF_HOLD;
        repeat (3) @(posedge clk_i);
    endtask : steer
    task automatic tally(input logic h);
        k = 0;
        repeat (32) begin
            @(posedge clk_i);
            k += h ? ring_halve_o : (ring_stages_o == 6'h13);
        end
    endtask : tally
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : close_out
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk("ratio", 10'h001, divide_ratio_o);
        chk("ring", 10'h011, 10'(ring_stages_o));
        chk("irq", 10'h000, 10'(irq_o));
        $display("test reset done");
        foreach (rows[i]) begin
            cpu.wr(rows[i].a, rows[i].d);
            cpu.rd(rows[i].a, s);
            chk("read", 10'(rows[i].e), 10'(s));
            if (rows[i].a == 4'h0) begin
                chk("select", 10'(rows[i].e[0]), 10'(osc_sel_external_o));
                chk("slow", 10'(rows[i].e[6]), 10'(external_slow_option_o));
            end
        end
        chk("factor", 10'h07F, 10'(multiply_factor_o));
        $display("test rows done");
        cpu.wr(4'h0, 8'h0C);
        internal_off_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        chk("osc sel", 10'h001, 10'(osc_sel_external_o));
        chk("tb sel", 10'h001, 10'(timebase_sel_external_o));
        chk("irq", 10'h001, 10'(irq_o));
        internal_off_i <= 1'b0;
        cpu.wr(4'h0, 8'h0D);
        repeat (2) @(posedge clk_i);
        chk("irq kept", 10'h001, 10'(irq_o));
        internal_stable_i <= 1'b0;
        @(posedge clk_i);
        cpu.rd(4'h0, s);
        chk("mon kept", 10'h001, 10'(s[2]));
        chk("sel bit", 10'h001, 10'(s[0]));
        internal_stable_i <= 1'b1;
        @(posedge clk_i);
        cpu.service(s);
        repeat (2) @(posedge clk_i);
        chk("irq clear", 10'h000, 10'(irq_o));
        cpu.rd(4'h0, s);
        chk("mon off", 10'h000, 10'(s[2]));
        cpu.wr(4'h0, 8'h0D);
        external_off_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        chk("osc sel ext", 10'h000, 10'(osc_sel_external_o));
        chk("tb sel ext", 10'h000, 10'(timebase_sel_external_o));
        external_off_i <= 1'b0;
        cpu.service(s);
        chk("sel bit ext", 10'h000, 10'(s[0]));
        chk("flag seen", 10'h001, 10'(s[1]));
        $display("test monitor done");
        steer(DCM_LF_UP, 300);
        chk("ratio", 10'h002, divide_ratio_o);
        steer(DCM_LF_UP, 2600);
        chk("ratio max", 10'h200, divide_ratio_o);
        steer(DCM_LF_RSVD, 8);
        chk("stage", 10'h0FF, 10'(dco_o.stage_control));
        steer(DCM_LF_DOWN, 2600);
        chk("ring min", 10'h011, 10'(ring_stages_o));
        steer(DCM_LF_UP, 5);
        tally(1'b0);
        chk("long share", 10'h005, 10'(k));
        steer(DCM_LF_UP, 222);
        tally(1'b1);
        chk("halved share", 10'h003, 10'(k));
        $display("test dco done");
        cpu.retune(7'h54);
        repeat (2) @(posedge clk_i);
        chk("factor", 10'h054, 10'(multiply_factor_o));
        cpu.rd(4'h0, s);
        chk("mon again", 10'h001, 10'(s[2]));
        $display("test retune done");
        close_out();
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        err_total++;
        close_out();
    end
endmodule : tb_top
